// *** design/dmasc_pkg.sv ***
// Purpose: Shared constants for the DMA channel service control block.
// Assumes: Four channels, 16-bit address and count, AHB-Lite registers.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package dmasc_pkg;
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_REQ = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0C;
   localparam logic [7:0] OFF_TEMP = 8'h10;
   localparam logic [7:0] OFF_MODE0 = 8'h20;
   localparam logic [7:0] OFF_ADDR0 = 8'h30;
   localparam logic [7:0] OFF_CNT0 = 8'h40;
   localparam logic [7:0] OFF_CURA0 = 8'h50;
   localparam logic [7:0] OFF_CURC0 = 8'h60;
   localparam int CMD_MM = 0;
   localparam int CMD_HOLD = 1;
   localparam int CMD_DIS = 2;
   localparam int CMD_ROT = 4;
   localparam int CMD_ACKHI = 7;
   localparam int MODE_TYPE = 2;
   localparam int MODE_AUTO = 4;
   localparam int MODE_DEC = 5;
   localparam int MODE_SVC = 6;
   localparam logic [1:0] TYPE_VERIFY = 2'h0;
   localparam logic [1:0] TYPE_WRITE = 2'h1;
   localparam logic [1:0] TYPE_READ = 2'h2;
   localparam logic [1:0] SVC_DEMAND = 2'h0;
   localparam logic [1:0] SVC_SINGLE = 2'h1;
   localparam logic [1:0] SVC_BLOCK = 2'h2;
   localparam logic [1:0] SVC_CASCADE = 2'h3;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [3:0] MASK_RESET = 4'hF;
   localparam logic [15:0] CNT_WRAP = 16'hFFFF;
   typedef enum logic [2:0] {
      DMASC_IDLE = 3'h0,
      DMASC_S0 = 3'h1,
      DMASC_S1 = 3'h3,
      DMASC_S2 = 3'h2,
      DMASC_S4 = 3'h6,
      DMASC_M1 = 3'h7,
      DMASC_CAS = 3'h5,
      DMASC_END = 3'h4
   } dmasc_state_e;
endpackage : dmasc_pkg

// *** design/dmasc_arbiter.sv ***
// Purpose: Picks the winning channel among pending requests.
// Assumes: Request vector already masked by the caller.
// Notes: Purely combinational; the caller samples it on grant.
`timescale 1ns/1ns
module dmasc_arbiter (
   input wire logic [3:0] pend_in,
   input wire logic rotate_in,
   input wire logic [1:0] last_in,
   output logic hit_out,
   output logic [1:0] win_out
);
   logic [1:0] start;
   logic [1:0] idx;
   always_comb begin
      // Rotation starts just after the last serviced channel.
      start = rotate_in ? 2'(last_in + 2'h1) : 2'h0;
      hit_out = 1'b0;
      win_out = 2'h0;
      idx = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         idx = 2'(start + 2'(i));
         if (pend_in[idx]) begin
            hit_out = 1'b1;
            win_out = idx;
         end
      end
   end
endmodule : dmasc_arbiter

// *** design/dmasc_top.sv ***
// Purpose: Active-cycle service control of a four-channel DMA engine.
// Assumes: AHB-Lite slave with single word transfers; one 250 MHz clock.
// Notes: Memory data bus and address latch are outside this block.
`timescale 1ns/1ns
module dmasc_top (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [3:0] chan_request_in,
   output logic [3:0] chan_ack_out,
   output logic hold_request_out,
   input wire logic hold_grant_in,
   input wire logic ready_in,
   input wire logic end_of_process_b_in,
   output logic end_of_process_b_out,
   output logic end_of_process_oe_b_out,
   output logic [15:0] addr_out,
   output logic upper_addr_enable_out,
   output logic mem_read_strobe_b_out,
   output logic mem_write_strobe_b_out,
   output logic io_read_strobe_b_out,
   output logic io_write_strobe_b_out,
   input wire logic [7:0] mem_data_in,
   output logic [7:0] mem_data_out
);
   logic [1:0] rst_sync_reg;
   logic rst_b;
   logic [3:0] chan_request_a_reg, chan_request_b_reg;
   logic [1:0] hold_grant_reg, rdy_reg, eop_reg;
   logic hold_grant, rdy, ext_eop;
   logic [7:0] cmd_reg;
   logic [3:0] mask_reg, sreq_reg, tc_reg;
   logic [7:0] temp_reg;
   logic [7:0] mode_reg [4];
   logic [15:0] base_a_reg [4];
   logic [15:0] base_c_reg [4];
   logic [15:0] cur_a_reg [4];
   logic [15:0] cur_c_reg [4];
   dmasc_pkg::dmasc_state_e state_reg;
   logic [1:0] ch_reg, last_reg;
   logic eop_pulse_reg;
   logic [3:0] ack_reg;
   logic [7:0] dph_addr_reg;
   logic dph_wr_reg;
   logic [3:0] pend;
   logic hit;
   logic [1:0] win;
   logic mm, mm_ch1, do_xfer, done, ext_end, chan_drop;
   logic [1:0] ttype, svc;
   logic [15:0] c_next;
   logic wr_hit, wr_go;
   logic [1:0] sel;
   logic [7:0] off;

   // A hold that lags the bus would let software race the engine.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_reg[1];

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         chan_request_a_reg <= 4'h0;
         chan_request_b_reg <= 4'h0;
         hold_grant_reg <= 2'h0;
         rdy_reg <= 2'h0;
         eop_reg <= 2'h3;
      end else begin
         chan_request_a_reg <= chan_request_in;
         chan_request_b_reg <= chan_request_a_reg;
         hold_grant_reg <= {hold_grant_reg[0], hold_grant_in};
         rdy_reg <= {rdy_reg[0], ready_in};
         eop_reg <= {eop_reg[0], end_of_process_b_in};
      end
   end
   assign hold_grant = hold_grant_reg[1];
   assign rdy = rdy_reg[1];
   assign ext_eop = !eop_reg[1];

   function automatic logic [15:0] step(input logic [15:0] a,
                                        input logic dec);
      step = dec ? 16'(a - 16'h0001) : 16'(a + 16'h0001);
   endfunction : step

   assign mm = cmd_reg[dmasc_pkg::CMD_MM];
   // Masks still gate cascade channels.
   assign pend = cmd_reg[dmasc_pkg::CMD_DIS] ? 4'h0 :
                 (sreq_reg | (chan_request_b_reg & ~mask_reg)) &
                 (mm ? 4'hD : 4'hF);
   assign ttype = mode_reg[ch_reg][dmasc_pkg::MODE_TYPE +: 2];
   assign svc = mode_reg[ch_reg][dmasc_pkg::MODE_SVC +: 2];
   assign c_next = 16'(cur_c_reg[mm_ch1 ? 2'h1 : ch_reg] - 16'h0001);
   assign mm_ch1 = mm && (ch_reg == 2'h0);
   // Verify ignores ready.
   assign do_xfer = (state_reg == dmasc_pkg::DMASC_S4) &&
                    (rdy || ttype == dmasc_pkg::TYPE_VERIFY || mm);
   // Count underflow marks the last transfer.
   assign done = c_next == dmasc_pkg::CNT_WRAP;
   assign ext_end = ext_eop && svc != dmasc_pkg::SVC_CASCADE;
   assign chan_drop = !chan_request_b_reg[ch_reg] && !sreq_reg[ch_reg];

   dmasc_arbiter u_arb (
      .pend_in(pend),
      .rotate_in(cmd_reg[dmasc_pkg::CMD_ROT]),
      .last_in(last_reg),
      .hit_out(hit),
      .win_out(win)
   );

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= dmasc_pkg::DMASC_IDLE;
         ch_reg <= 2'h0;
         last_reg <= 2'h3;
         eop_pulse_reg <= 1'b0;
      end else begin
         eop_pulse_reg <= 1'b0;
         case (state_reg)
            dmasc_pkg::DMASC_IDLE: begin
               if (hit) begin
                  state_reg <= dmasc_pkg::DMASC_S0;
               end
            end
            dmasc_pkg::DMASC_S0: begin
               if (hold_grant) begin
                  // Winner chosen fresh on each grant; memory-to-memory always takes channel 0.
                  ch_reg <= mm ? 2'h0 : win;
                  if (!hit) begin
                     state_reg <= dmasc_pkg::DMASC_END;
                  end else if (!mm && mode_reg[win][dmasc_pkg::MODE_SVC +: 2]
                               == dmasc_pkg::SVC_CASCADE) begin
                     state_reg <= dmasc_pkg::DMASC_CAS;
                  end else begin
                     state_reg <= dmasc_pkg::DMASC_S1;
                  end
               end
            end
            dmasc_pkg::DMASC_S1: begin
               state_reg <= dmasc_pkg::DMASC_S2;
            end
            dmasc_pkg::DMASC_S2: begin
               state_reg <= dmasc_pkg::DMASC_S4;
            end
            dmasc_pkg::DMASC_S4: begin
               if (do_xfer && mm) begin
                  state_reg <= dmasc_pkg::DMASC_M1;
               end else if (do_xfer) begin
                  eop_pulse_reg <= done || ext_end;
                  // No other channel cuts in mid-service.
                  if (done || ext_end ||
                      svc == dmasc_pkg::SVC_SINGLE ||
                      (svc == dmasc_pkg::SVC_DEMAND && chan_drop)) begin
                     state_reg <= dmasc_pkg::DMASC_END;
                  end else begin
                     state_reg <= dmasc_pkg::DMASC_S2;
                  end
               end
            end
            dmasc_pkg::DMASC_M1: begin
               // Write half finishes before any end.
               eop_pulse_reg <= done || ext_eop;
               state_reg <= (done || ext_eop) ? dmasc_pkg::DMASC_END :
                            dmasc_pkg::DMASC_S2;
            end
            dmasc_pkg::DMASC_CAS: begin
               if (!hold_grant || !pend[ch_reg]) begin
                  state_reg <= dmasc_pkg::DMASC_END;
               end
            end
            dmasc_pkg::DMASC_END: begin
               last_reg <= ch_reg;
               if (!hold_grant) begin
                  state_reg <= dmasc_pkg::DMASC_IDLE;
               end
            end
            default: begin
               state_reg <= dmasc_pkg::DMASC_IDLE;
            end
         endcase
      end
   end

   assign hold_request_out = state_reg != dmasc_pkg::DMASC_IDLE &&
                             state_reg != dmasc_pkg::DMASC_END;

   // Acknowledge asserts once the channel owns the bus, except in memory-to-memory mode.
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 4'h0;
      end else begin
         ack_reg <= 4'h0;
         if (!mm && (state_reg == dmasc_pkg::DMASC_S1 ||
             state_reg == dmasc_pkg::DMASC_S2 ||
             state_reg == dmasc_pkg::DMASC_S4 ||
             state_reg == dmasc_pkg::DMASC_CAS)) begin
            ack_reg[ch_reg] <= 1'b1;
         end
      end
   end
   assign chan_ack_out = cmd_reg[dmasc_pkg::CMD_ACKHI] ? ack_reg : ~ack_reg;

   // Strobes pair by transfer type; cascade drives none.
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         mem_read_strobe_b_out <= 1'b1;
         mem_write_strobe_b_out <= 1'b1;
         io_read_strobe_b_out <= 1'b1;
         io_write_strobe_b_out <= 1'b1;
         upper_addr_enable_out <= 1'b0;
         addr_out <= 16'h0000;
         end_of_process_b_out <= 1'b1;
         end_of_process_oe_b_out <= 1'b1;
      end else begin
         mem_read_strobe_b_out <= !((state_reg == dmasc_pkg::DMASC_S2 ||
            state_reg == dmasc_pkg::DMASC_S4) &&
            (mm || ttype == dmasc_pkg::TYPE_READ));
         mem_write_strobe_b_out <= !((state_reg == dmasc_pkg::DMASC_S4 &&
            !mm && ttype == dmasc_pkg::TYPE_WRITE) ||
            state_reg == dmasc_pkg::DMASC_M1);
         io_read_strobe_b_out <= !(!mm && ttype == dmasc_pkg::TYPE_WRITE &&
            (state_reg == dmasc_pkg::DMASC_S2 ||
             state_reg == dmasc_pkg::DMASC_S4));
         io_write_strobe_b_out <= !(!mm && ttype == dmasc_pkg::TYPE_READ &&
            state_reg == dmasc_pkg::DMASC_S4);
         upper_addr_enable_out <= state_reg == dmasc_pkg::DMASC_S1 ||
            state_reg == dmasc_pkg::DMASC_S2 ||
            state_reg == dmasc_pkg::DMASC_S4 ||
            state_reg == dmasc_pkg::DMASC_M1;
         addr_out <= (state_reg == dmasc_pkg::DMASC_M1) ? cur_a_reg[1] :
                     cur_a_reg[ch_reg];
         end_of_process_b_out <= !eop_pulse_reg;
         end_of_process_oe_b_out <= !eop_pulse_reg;
      end
   end

   assign wr_hit = hsel_in && hready_in && htrans_in[1];
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         dph_wr_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
      end else if (hready_in) begin
         dph_wr_reg <= wr_hit && hwrite_in;
         dph_addr_reg <= haddr_in[7:0];
      end
   end
   // Software writes only take effect while hold is not requested (idle or end state).
   assign wr_go = dph_wr_reg && !hold_request_out;
   assign off = dph_addr_reg;
   assign sel = off[3:2];

   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         cmd_reg <= dmasc_pkg::CMD_RESET;
         temp_reg <= 8'h00;
      end else begin
         if (wr_go && off == dmasc_pkg::OFF_CMD) begin
            cmd_reg <= hwdata_in[7:0];
         end
         if (state_reg == dmasc_pkg::DMASC_S4 && mm && do_xfer) begin
            temp_reg <= mem_data_in;
         end
      end
   end
   assign mem_data_out = temp_reg;

   // Status flags: hardware set wins over a software clear.
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         mask_reg <= dmasc_pkg::MASK_RESET;
         sreq_reg <= 4'h0;
         tc_reg <= 4'h0;
      end else begin
         if (wr_go && off == dmasc_pkg::OFF_MASK) begin
            mask_reg <= hwdata_in[3:0];
         end
         if (wr_go && off == dmasc_pkg::OFF_REQ) begin
            sreq_reg <= hwdata_in[3:0];
         end
         if (wr_go && off == dmasc_pkg::OFF_STATUS) begin
            tc_reg <= tc_reg & ~hwdata_in[3:0];
         end
         if (state_reg == dmasc_pkg::DMASC_S4 && do_xfer && !mm && done) begin
            tc_reg[ch_reg] <= 1'b1;
            sreq_reg[ch_reg] <= 1'b0;
            if (!mode_reg[ch_reg][dmasc_pkg::MODE_AUTO]) begin
               mask_reg[ch_reg] <= 1'b1;
            end
         end
         if (state_reg == dmasc_pkg::DMASC_M1 && (done || ext_eop)) begin
            sreq_reg[0] <= 1'b0;
            if (done) begin
               tc_reg[1] <= 1'b1;
            end
            if (!mode_reg[1][dmasc_pkg::MODE_AUTO]) begin
               mask_reg[1] <= 1'b1;
            end
         end
         if (state_reg == dmasc_pkg::DMASC_S4 && do_xfer && !mm &&
             ext_end) begin
            sreq_reg[ch_reg] <= 1'b0;
         end
      end
   end

   // Per-channel mode, base and current words.
   always_ff @(posedge mclk_in or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            mode_reg[i] <= 8'h00;
            base_a_reg[i] <= 16'h0000;
            base_c_reg[i] <= 16'h0000;
            cur_a_reg[i] <= 16'h0000;
            cur_c_reg[i] <= 16'h0000;
         end
      end else begin
         if (wr_go && off[7:4] == dmasc_pkg::OFF_MODE0[7:4]) begin
            mode_reg[sel] <= hwdata_in[7:0];
         end
         if (wr_go && off[7:4] == dmasc_pkg::OFF_ADDR0[7:4]) begin
            base_a_reg[sel] <= hwdata_in[15:0];
            cur_a_reg[sel] <= hwdata_in[15:0];
         end
         if (wr_go && off[7:4] == dmasc_pkg::OFF_CNT0[7:4]) begin
            base_c_reg[sel] <= hwdata_in[15:0];
            cur_c_reg[sel] <= hwdata_in[15:0];
         end
         if (do_xfer && !mm) begin
            cur_c_reg[ch_reg] <= c_next;
            cur_a_reg[ch_reg] <= step(cur_a_reg[ch_reg],
               mode_reg[ch_reg][dmasc_pkg::MODE_DEC]);
            if ((done || ext_end) &&
                mode_reg[ch_reg][dmasc_pkg::MODE_AUTO]) begin
               cur_a_reg[ch_reg] <= base_a_reg[ch_reg];
               cur_c_reg[ch_reg] <= base_c_reg[ch_reg];
            end
         end
         if (do_xfer && mm) begin
            cur_c_reg[0] <= 16'(cur_c_reg[0] - 16'h0001);
            if (!cmd_reg[dmasc_pkg::CMD_HOLD]) begin
               cur_a_reg[0] <= step(cur_a_reg[0],
                  mode_reg[0][dmasc_pkg::MODE_DEC]);
            end
            if (cur_c_reg[0] == 16'h0000 &&
                mode_reg[0][dmasc_pkg::MODE_AUTO]) begin
               cur_a_reg[0] <= base_a_reg[0];
               cur_c_reg[0] <= base_c_reg[0];
            end
         end
         if (state_reg == dmasc_pkg::DMASC_M1) begin
            cur_c_reg[1] <= c_next;
            cur_a_reg[1] <= step(cur_a_reg[1],
               mode_reg[1][dmasc_pkg::MODE_DEC]);
            if ((done || ext_eop) && mode_reg[1][dmasc_pkg::MODE_AUTO]) begin
               cur_a_reg[1] <= base_a_reg[1];
               cur_c_reg[1] <= base_c_reg[1];
            end
         end
      end
   end

   always_comb begin
      hrdata_out = 32'h0000_0000;
      case (off[7:4])
         4'h0: begin
            case (sel)
               2'h0: hrdata_out = {24'h000000, cmd_reg};
               2'h1: hrdata_out = {24'h000000, sreq_reg, tc_reg};
               2'h2: hrdata_out = {28'h0000000, sreq_reg};
               default: hrdata_out = {28'h0000000, mask_reg};
            endcase
         end
         4'h1: hrdata_out = {24'h000000, temp_reg};
         4'h2: hrdata_out = {24'h000000, mode_reg[sel]};
         4'h3: hrdata_out = {16'h0000, base_a_reg[sel]};
         4'h4: hrdata_out = {16'h0000, base_c_reg[sel]};
         4'h5: hrdata_out = {16'h0000, cur_a_reg[sel]};
         4'h6: hrdata_out = {16'h0000, cur_c_reg[sel]};
         default: hrdata_out = 32'h0000_0000;
      endcase
   end
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
endmodule : dmasc_top

// *** verif/dmasc_checker.sv ***
// Purpose: Port level checks for the DMA service control block.
// Assumes: Acknowledges stay at their reset polarity in the bench.
// Notes: Strobe pairing is checked per edge, not per transfer.
`timescale 1ns/1ns
module dmasc_checker (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic [3:0] chan_ack_out,
   input wire logic hold_request_out,
   input wire logic hold_grant_in,
   input wire logic end_of_process_b_out,
   input wire logic end_of_process_oe_b_out,
   input wire logic mem_read_strobe_b_out,
   input wire logic mem_write_strobe_b_out,
   input wire logic io_read_strobe_b_out,
   input wire logic io_write_strobe_b_out,
   input wire logic upper_addr_enable_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   reset_ack_a: assert property (
      $rose(rst_b_in) |-> chan_ack_out == 4'hF) else $error("ack active");
   bus_okay_a: assert property (hreadyout_out && !hresp_out)
      else $error("bus not okay");
   hold_rise_a: assert property (
      $rose(hold_request_out) |-> !hold_grant_in) else $error("early hold");
   // The I/O read leads the memory write by one state in write transfers.
   write_pair_a: assert property (
      !io_read_strobe_b_out |-> ##[0:1] !mem_write_strobe_b_out)
      else $error("write pair");
   read_pair_a: assert property (
      !io_write_strobe_b_out |-> !mem_read_strobe_b_out)
      else $error("read pair");
   // Strobes are registered, so they lag the owning state by one edge.
   strobe_owner_a: assert property (
      !(mem_read_strobe_b_out && mem_write_strobe_b_out &&
      io_read_strobe_b_out && io_write_strobe_b_out)
      |-> $past(hold_request_out && hold_grant_in))
      else $error("strobe no bus");
   aen_owner_a: assert property (
      upper_addr_enable_out |-> $past(hold_request_out && hold_grant_in))
      else $error("address without bus");
   eop_pulse_a: assert property (
      $fell(end_of_process_b_out) |=> end_of_process_b_out)
      else $error("eop too long");
   eop_drive_a: assert property (
      !end_of_process_b_out |-> !end_of_process_oe_b_out)
      else $error("eop undriven");
endmodule : dmasc_checker

// *** verif/dmasc_partner.sv ***
// Purpose: Host hold grant and I/O requester model.
// Assumes: Acknowledges active low.
// Notes: Grant needs three steady cycles, so it never races a re-request.
`timescale 1ns/1ns
module dmasc_partner (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic hold_request_in,
   input wire logic [3:0] chan_ack_b_in,
   input wire logic [3:0] want_in,
   output logic hold_grant_out,
   output logic [3:0] chan_request_out
);
   logic [2:0] lag_reg;
   logic [3:0] pend_reg;
   logic [3:0] want_d_reg;
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lag_reg <= 3'h0;
      end else begin
         lag_reg <= {lag_reg[1:0], hold_request_in};
      end
   end
   assign hold_grant_out = (&lag_reg) & hold_request_in;
   // A new request is kept until its acknowledge shows. A level still held
   // after service is not latched again, so it cannot outlive its caller.
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pend_reg <= 4'h0;
         want_d_reg <= 4'h0;
      end else begin
         want_d_reg <= want_in;
         pend_reg <= (pend_reg | (want_in & ~want_d_reg)) &
                     chan_ack_b_in;
      end
   end
   assign chan_request_out = want_in | pend_reg;
endmodule : dmasc_partner

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the DMA service control block.
// Assumes: Zero wait register bus; model grants the bus.
// Notes: Strobe falls are running totals, compared as deltas.
`timescale 1ns/1ns
module tb;
   logic mclk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy;
   logic hreq, hgnt, eop, mr, mw, ir, iw;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [3:0] want = 4'h0, creq, ack;
   logic [5:0] prev = 6'h3F;
   logic [5:0] lvl;
   logic rdy_in = 1'b1;
   logic [15:0] addr;
   logic [7:0] mdo;
   int cnt[6] = '{default: 0};
   int base[6];
   int err_total = 0, samples_checked = 0;
   initial forever #2 mclk = ~mclk;
   dmasc_top DUT (.mclk_in(mclk), .rst_b_in(rst_b), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
      .chan_request_in(creq), .chan_ack_out(ack),
      .hold_request_out(hreq), .hold_grant_in(hgnt), .ready_in(rdy_in),
      .end_of_process_b_in(1'b1), .end_of_process_b_out(eop),
      .end_of_process_oe_b_out(), .addr_out(addr),
      .upper_addr_enable_out(), .mem_read_strobe_b_out(mr),
      .mem_write_strobe_b_out(mw), .io_read_strobe_b_out(ir),
      .io_write_strobe_b_out(iw), .mem_data_in(8'h5A), .mem_data_out(mdo));
   dmasc_partner host_u (.mclk_in(mclk), .rst_b_in(rst_b),
      .hold_request_in(hreq), .chan_ack_b_in(ack), .want_in(want),
      .hold_grant_out(hgnt), .chan_request_out(creq));
   assign lvl = {~hreq, eop, iw, ir, mw, mr};
   always @(posedge mclk) begin
      for (int i = 0; i < 6; i++) begin
         if (prev[i] && !lvl[i])
            cnt[i] <= cnt[i] + 1;
      end
      prev <= lvl;
   end
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [31:0] delta();
      logic [31:0] d;
      d = 32'h0;
      for (int i = 0; i < 6; i++) d[i*4 +: 4] = 4'(cnt[i] - base[i]);
      return d;
   endfunction : delta
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string n, input logic [7:0] a,
         input logic [31:0] e, input logic [31:0] m = 32'hFFFF);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, e, q & m);
   endtask : rd
   task automatic prog(input int c, input logic [7:0] md,
         input logic [15:0] a, input logic [15:0] n);
      wr(dmasc_pkg::OFF_MODE0 + 8'(4 * c), {24'h0, md});
      wr(dmasc_pkg::OFF_ADDR0 + 8'(4 * c), {16'h0, a});
      wr(dmasc_pkg::OFF_CNT0 + 8'(4 * c), {16'h0, n});
      base = cnt;
   endtask : prog
   task automatic run();
      int n;
      n = 0;
      while (hreq !== 1'b1 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      chk("hold", 32'h1, {31'h0, hreq});
      n = 0;
      while (n < 40) begin
         @(posedge mclk);
         n = (hreq !== 1'b0) ? 0 : n + 1;
      end
   endtask : run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd("cmd", 8'h00, 32'h0);
      rd("unmapped", 8'h7C, 32'h0);
      chk("ack", 32'hF, {28'h0, ack});
      prog(2, 8'h44, 16'h1000, 16'h0001);
      wr(8'h0C, 32'hB);
      want <= 4'h4;
      run();
      want <= 4'h0;
      chk("single", 32'h210220, delta());
      rd("c2 addr", 8'h58, 32'h1002);
      rd("c2 count", 8'h68, 32'hFFFF);
      rd("status", 8'h04, 32'h4, 32'hF);
      rd("mask", 8'h0C, 32'hF);
      chk("addr pins", 32'h1002, {16'h0, addr});
      wr(8'h04, 32'hF);
      prog(1, 8'hB8, 16'h2000, 16'h0002);
      wr(8'h0C, 32'hD);
      want <= 4'h2;
      @(posedge mclk);
      want <= 4'h0;
      run();
      chk("block", 32'h113001, delta());
      rd("c1 addr", 8'h54, 32'h2000);
      rd("c1 count", 8'h64, 32'h0002);
      rd("status", 8'h04, 32'h2, 32'hF);
      rd("mask", 8'h0C, 32'hD);
      wr(8'h04, 32'hF);
      prog(0, 8'h00, 16'h0100, 16'h0000);
      wr(8'h0C, 32'hE);
      rdy_in <= 1'b0;
      want <= 4'h1;
      run();
      want <= 4'h0;
      rdy_in <= 1'b1;
      chk("verify", 32'h110000, delta());
      rd("c0 count", 8'h60, 32'hFFFF);
      rd("c0 addr", 8'h50, 32'h0101);
      wr(8'h04, 32'hF);
      prog(0, 8'h88, 16'h3000, 16'h0001);
      prog(1, 8'h84, 16'h4000, 16'h0001);
      wr(8'h0C, 32'hC);
      wr(8'h00, 32'h3);
      wr(8'h08, 32'h1);
      run();
      chk("move", 32'h110022, delta());
      rd("temp", 8'h10, 32'h5A);
      rd("c0 held", 8'h50, 32'h3000);
      rd("c1 addr", 8'h54, 32'h4002);
      rd("c1 count", 8'h64, 32'hFFFF);
      rd("status", 8'h04, 32'h2, 32'hF);
      rd("mask", 8'h0C, 32'hE);
      chk("data pins", 32'h5A, {24'h0, mdo});
      wr(8'h00, 32'h0);
      prog(3, 8'hC0, 16'h0000, 16'h0000);
      want <= 4'h8;
      @(posedge mclk);
      want <= 4'h0;
      repeat (20) @(posedge mclk);
      chk("masked", 32'h0, {31'h0, hreq});
      wr(8'h0C, 32'h7);
      run();
      chk("cascade", 32'h100000, delta());
      rd("c3 count", 8'h6C, 32'h0);
      rd("mask", 8'h0C, 32'h7);
      tally_and_finish();
   end
endmodule : tb
bind dmasc_top dmasc_checker chk_u (.mclk_in, .rst_b_in, .hreadyout_out,
   .hresp_out, .chan_ack_out, .hold_request_out, .hold_grant_in,
   .end_of_process_b_out, .end_of_process_oe_b_out,
   .mem_read_strobe_b_out, .mem_write_strobe_b_out,
   .io_read_strobe_b_out, .io_write_strobe_b_out, .upper_addr_enable_out);
